// ### rtl/rcp_pkg.sv
// Purpose: Shared constants and carrier types for the remote control pins.
// Assumes: One 20 MHz clock; AXI4-Lite registers of 32-bit words.
// Notes: Millisecond times are counted on a one-cycle tick enable.
package rcp_pkg;
   // Clock and tick rate.
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Times in milliseconds, and the press count for factory defaults.
   localparam logic [7:0] ACK_DEF_MS = 8'h14;
   localparam logic [9:0] HOLD_MS = 10'h2f8;
   localparam logic [9:0] PAIR_MS = 10'h3e8;
   localparam logic [9:0] GAP_MS = 10'h1f4;
   localparam logic [9:0] BLINK_MS = 10'h3e8;
   localparam logic [9:0] ON_LISTEN_MS = 10'h032;
   localparam logic [9:0] ON_SEND_MS = 10'h0c8;
   localparam logic [9:0] ON_PAIR_MS = 10'h1f4;
   localparam logic [2:0] RESET_PRESSES = 3'h5;
   // Positions in the raw pin vector.
   localparam int PIN_ST = 6;
   localparam int PIN_LODIR = 5;
   localparam int PIN_HIDIR = 4;
   localparam int PIN_LPN = 3;
   localparam int PIN_TOG = 2;
   localparam int PIN_PERMIT = 1;
   localparam int PIN_CMD = 0;
   localparam int PIN_BTN = 14;
   // Register map, fields and bus answers.
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS = 32'h0000_0004;
   localparam int CTRL_PAIR_BIT = 8;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      MD_LOWPWR = 4'h1,
      MD_LISTEN = 4'h2,
      MD_SEND = 4'h4,
      MD_PAIR = 4'h8
   } rcp_mode_t;

   // From the radio protocol engine.
   typedef struct packed {
      logic rx_busy;
      logic tx_busy;
      logic pkt_valid;
      logic [7:0] pkt_bits;
      logic ack_valid;
      logic [7:0] ack_ms;
      logic cmd_tx;
   } rcp_core_in_t;

   // To the radio protocol engine.
   typedef struct packed {
      logic send_req;
      logic [7:0] send_bits;
      logic reply_req;
      logic pair_start;
      logic factory_reset;
      logic cmd_rx;
      logic sleep;
   } rcp_core_out_t;

   typedef struct packed {
      logic [14:0] p1;
      logic [14:0] p2;
      logic [8:0] samp;
      logic [8:0] deb;
      logic [15:0] div;
      logic tick;
      logic [7:0] prev_pkt;
      logic [7:0] line_out;
      logic [7:0] line_oe;
      logic [9:0] hold;
      logic [7:0] ack_def;
      logic [7:0] ack_cnt;
      logic ack_out;
      logic [9:0] gap;
      logic [2:0] presses;
      logic [9:0] pair_tmr;
      rcp_mode_t mode;
      logic [9:0] blink;
      logic light;
      logic rx_amp;
      logic tx_amp;
      logic cmd_out;
      rcp_core_out_t core;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [31:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } rcp_state_t;
endpackage

// ### rtl/rcp_pin_logic.sv
// Purpose: Pin logic of a remote control transceiver: status lines,
//    straps, amplifier enables, acknowledgement, pairing, indicator.
// Assumes: Radio protocol engine sits on core_in/core_out.
// Notes: Packet protocol, hopping and command set live in the engine.
// Operation
// - Low strap low makes lines 0-3 outputs, high makes them inputs.
// - High strap low makes lines 4-7 outputs, high makes them inputs.
// - Low-power input low stops all function but the AXI4-Lite registers and command input pass-through until it is high again.
// - Toggle select high: activation commands flip outputs.
// - Toggle select low: outputs stay active only while packets arrive.
// - Active-low reset clears the block but sets the 20 ms ack default, listening mode and high command output.
// - Receive amplifier enable is high while receiving.
// - Transmit amplifier enable is high while transmitting.
// - Valid control packet answered only when reply permit is high.
// - Button high starts pairing.
// - A press pattern on the button restores factory defaults.
// - Acknowledgement output rises when an acknowledgement arrives.
// - Indicator pulses, pulse length shows state, drives small LED.
// - Serial commands come in on one line, answers go out another.
// - Status bit n maps to status line n between units.
// - Momentary outputs equal bits of the latest packet.
// - Toggle outputs flip only on a 0 to 1 bit change.
// - Acknowledgement output lasts the CTRL default, 20 ms at reset, unless the reply gives a nonzero length.
`timescale 1ns/100ps
module rcp_pin_logic #(
   parameter int MS_CYC = rcp_pkg::MS_CYC
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Status lines, split into input, output and enable.
   input wire logic [7:0] status_line_in,
   output logic [7:0] status_line_out,
   output logic [7:0] status_line_oe,
   // Straps and control inputs.
   input wire logic low_group_direction,
   input wire logic high_group_direction,
   input wire logic low_power_n,
   input wire logic toggle_select,
   input wire logic reply_permit,
   input wire logic pairing_button,
   input wire logic cmd_in,
   // Pin outputs.
   output logic cmd_out,
   output logic rx_amp_enable,
   output logic tx_amp_enable,
   output logic ack_out,
   output logic activity_light,
   // Radio protocol engine.
   input wire rcp_pkg::rcp_core_in_t core_in,
   output rcp_pkg::rcp_core_out_t core_out
);

   // The millisecond divider is 16 bits wide.
   if (MS_CYC < 2 || MS_CYC > 65535) begin : g_bad_ms
      $error("MS_CYC out of range");
   end

   rcp_pkg::rcp_state_t q;
   rcp_pkg::rcp_state_t d;
   logic [14:0] pin_raw;

   // Indicator on-time for each operating mode.
   function automatic logic [9:0] on_time(input rcp_pkg::rcp_mode_t m);
      case (m)
         rcp_pkg::MD_LISTEN: on_time = rcp_pkg::ON_LISTEN_MS;
         rcp_pkg::MD_SEND: on_time = rcp_pkg::ON_SEND_MS;
         rcp_pkg::MD_PAIR: on_time = rcp_pkg::ON_PAIR_MS;
         default: on_time = 10'h000;
      endcase
   endfunction

   // Register decode shared by the read and write paths.
   function automatic logic [1:0] reg_sel(input logic [31:0] a);
      if (a[31:2] == rcp_pkg::CTRL_OFS[31:2]) begin
         reg_sel = 2'h1;
      end else if (a[31:2] == rcp_pkg::STAT_OFS[31:2]) begin
         reg_sel = 2'h2;
      end else begin
         reg_sel = 2'h0;
      end
   endfunction

   // Raw pin vector; only the first synchroniser stage reads it.
   assign pin_raw = {pairing_button, status_line_in, low_group_direction,
      high_group_direction, low_power_n, toggle_select, reply_permit,
      cmd_in};

   // Next-state logic for the whole block.
   always_comb begin
      logic lp;
      logic tog;
      logic btn_rise;
      logic soft_pair;
      logic [7:0] in_mask;
      logic [7:0] rise;
      logic [31:0] stat;
      d = q;
      lp = 1'b0;
      tog = 1'b0;
      btn_rise = 1'b0;
      soft_pair = 1'b0;
      in_mask = 8'h00;
      rise = 8'h00;
      stat = 32'h0000_0000;

      // Two-stage synchronisers on every pin input.
      d.p1 = pin_raw;
      d.p2 = q.p1;
      lp = ~q.p2[rcp_pkg::PIN_LPN];
      tog = q.p2[rcp_pkg::PIN_TOG];

      // Millisecond tick; long times are counted on it.
      d.tick = 1'b0;
      if (q.div == 16'(MS_CYC - 1)) begin
         d.div = 16'h0000;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 16'h0001;
      end

      // A line is accepted only after two equal samples a tick apart.
      if (q.tick) begin
         d.samp = {q.p2[rcp_pkg::PIN_BTN], q.p2[rcp_pkg::PIN_ST +: 8]};
         d.deb = (d.samp & q.samp) | (q.deb & (d.samp | q.samp));
      end
      btn_rise = d.deb[8] & ~q.deb[8];

      // Strap high means input; outputs enabled only for low straps.
      in_mask = {{4{q.p2[rcp_pkg::PIN_HIDIR]}},
         {4{q.p2[rcp_pkg::PIN_LODIR]}}};
      d.line_oe = lp ? 8'h00 : ~in_mask;

      // Input lines go out bit for bit; any high line asks to send.
      d.core.send_bits = lp ? 8'h00 : (q.deb[7:0] & in_mask);
      d.core.send_req = |d.core.send_bits;

      // Pulses to the engine last one cycle.
      d.core.reply_req = 1'b0;
      d.core.pair_start = 1'b0;
      d.core.factory_reset = 1'b0;
      d.core.sleep = lp;

      // Received status packet updates the output lines.
      if (lp) begin
         d.line_out = 8'h00;
         d.prev_pkt = 8'h00;
         d.hold = 10'h000;
      end else if (core_in.pkt_valid) begin
         d.prev_pkt = core_in.pkt_bits;
         d.hold = rcp_pkg::HOLD_MS;
         if (tog) begin
            rise = core_in.pkt_bits & ~q.prev_pkt;
            d.line_out = q.line_out ^ rise;
         end else begin
            d.line_out = core_in.pkt_bits;
         end
         d.core.reply_req = q.p2[rcp_pkg::PIN_PERMIT];
      end else if (q.tick && q.hold != 10'h000) begin
         d.hold = q.hold - 10'h001;
         // Momentary lines drop once packets stop arriving.
         if (q.hold == 10'h001 && !tog) begin
            d.line_out = 8'h00;
         end
      end

      // Acknowledgement output timer in milliseconds.
      if (lp) begin
         d.ack_cnt = 8'h00;
      end else if (core_in.ack_valid) begin
         d.ack_cnt = (core_in.ack_ms == 8'h00) ? q.ack_def
            : core_in.ack_ms;
      end else if (q.tick && q.ack_cnt != 8'h00) begin
         d.ack_cnt = q.ack_cnt - 8'h01;
      end
      d.ack_out = (d.ack_cnt != 8'h00);

      // AXI4-Lite write: address and data taken in either order.
      d.awready = ~q.aw_got & ~q.bvalid & ~(s_axi_awvalid & q.awready);
      d.wready = ~q.w_got & ~q.bvalid & ~(s_axi_wvalid & q.wready);
      if (s_axi_awvalid && q.awready) begin
         d.aw_got = 1'b1;
         d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = rcp_pkg::RESP_OK;
         case (reg_sel(q.waddr))
            2'h1: begin
               if (q.wstrb[0]) begin
                  d.ack_def = q.wdata[7:0];
               end
               soft_pair = q.wstrb[1] & q.wdata[rcp_pkg::CTRL_PAIR_BIT];
            end
            2'h2: begin
               // Status word is read-only; writes are dropped.
            end
            default: d.bresp = rcp_pkg::RESP_SLVERR;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // Pairing and factory-default press counting.
      if (q.tick && q.gap != 10'h000) begin
         d.gap = q.gap - 10'h001;
         if (q.gap == 10'h001) begin
            d.presses = 3'h0;
         end
      end
      if (q.tick && q.pair_tmr != 10'h000) begin
         d.pair_tmr = q.pair_tmr - 10'h001;
      end
      if (!lp && (btn_rise || soft_pair)) begin
         d.core.pair_start = 1'b1;
         d.pair_tmr = rcp_pkg::PAIR_MS;
      end
      if (!lp && btn_rise) begin
         d.gap = rcp_pkg::GAP_MS;
         if (q.presses == rcp_pkg::RESET_PRESSES - 3'h1) begin
            d.core.factory_reset = 1'b1;
            d.ack_def = rcp_pkg::ACK_DEF_MS;
            d.presses = 3'h0;
         end else begin
            d.presses = q.presses + 3'h1;
         end
      end
      if (lp) begin
         d.pair_tmr = 10'h000;
         d.presses = 3'h0;
         d.gap = 10'h000;
      end

      // Amplifier enables follow the radio activity.
      d.rx_amp = ~lp & core_in.rx_busy;
      d.tx_amp = ~lp & core_in.tx_busy;

      // Operating mode shown on the indicator.
      if (lp) begin
         d.mode = rcp_pkg::MD_LOWPWR;
      end else if (d.pair_tmr != 10'h000) begin
         d.mode = rcp_pkg::MD_PAIR;
      end else if (core_in.tx_busy) begin
         d.mode = rcp_pkg::MD_SEND;
      end else begin
         d.mode = rcp_pkg::MD_LISTEN;
      end

      // Indicator: fixed period, on-time set by the mode.
      if (q.tick) begin
         d.blink = (q.blink == rcp_pkg::BLINK_MS - 10'h001) ? 10'h000
            : q.blink + 10'h001;
      end
      d.light = ~lp & (q.blink < on_time(q.mode));

      // Serial command lines pass through; output idles high.
      d.core.cmd_rx = q.p2[rcp_pkg::PIN_CMD];
      d.cmd_out = lp | core_in.cmd_tx;

      // AXI4-Lite read: answer one cycle after the address is taken.
      stat[7:0] = q.line_out;
      stat[15:8] = q.line_oe;
      stat[19:16] = q.mode;
      stat[20] = q.ack_out;
      stat[21] = q.core.send_req;
      d.arready = ~q.rvalid & ~(s_axi_arvalid & q.arready);
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = rcp_pkg::RESP_OK;
         case (reg_sel(s_axi_araddr))
            2'h1: d.rdata = {24'h00_0000, q.ack_def};
            2'h2: d.rdata = stat;
            default: begin
               d.rdata = 32'h0000_0000;
               d.rresp = rcp_pkg::RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   // State register; reset returns every field to a fixed value.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.ack_def <= rcp_pkg::ACK_DEF_MS;
         q.mode <= rcp_pkg::MD_LISTEN;
         q.cmd_out <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Every output comes straight from the state register.
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bresp = q.bresp;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rvalid = q.rvalid;
   assign status_line_out = q.line_out;
   assign status_line_oe = q.line_oe;
   assign cmd_out = q.cmd_out;
   assign rx_amp_enable = q.rx_amp;
   assign tx_amp_enable = q.tx_amp;
   assign ack_out = q.ack_out;
   assign activity_light = q.light;
   assign core_out = q.core;

endmodule

// ### verif/rcp_pin_checker.sv
// Purpose: Concurrent checks on the pin logic ports.
// Assumes: Outputs follow the pins within five cycles, reset included.
// Notes: Synchronisers restart empty at reset, so windows are four or five long.
`timescale 1ns/100ps
module rcp_pin_checker (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Pins.
   input wire logic low_group_direction,
   input wire logic high_group_direction,
   input wire logic low_power_n,
   input wire logic toggle_select,
   input wire logic reply_permit,
   input wire logic [7:0] status_line_out,
   input wire logic [7:0] status_line_oe,
   input wire logic rx_amp_enable,
   input wire logic tx_amp_enable,
   input wire logic cmd_out,
   input wire logic ack_out,
   // Engine side.
   input wire rcp_pkg::rcp_core_in_t core_in,
   input wire rcp_pkg::rcp_core_out_t core_out
);
   // One domain, so clock and reset are given once.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   lo_dir_a: assert property (
      (low_power_n && $stable(low_group_direction))[*5]
      |-> status_line_oe[3:0] == {4{!low_group_direction}})
      else $error("Low group direction wrong.");
   hi_dir_a: assert property (
      (low_power_n && $stable(high_group_direction))[*5]
      |-> status_line_oe[7:4] == {4{!high_group_direction}})
      else $error("High group direction wrong.");
   low_power_a: assert property (
      (!low_power_n)[*4] |-> status_line_oe == 8'h00 && !rx_amp_enable
      && !tx_amp_enable && core_out.sleep)
      else $error("Block active in low power.");
   rx_amp_a: assert property (
      low_power_n[*5] |-> rx_amp_enable == $past(core_in.rx_busy))
      else $error("Receive amplifier enable wrong.");
   tx_amp_a: assert property (
      low_power_n[*5] |-> tx_amp_enable == $past(core_in.tx_busy))
      else $error("Transmit amplifier enable wrong.");
   mom_pkt_a: assert property (
      (low_power_n && !toggle_select)[*4] ##0 core_in.pkt_valid
      |=> status_line_out == $past(core_in.pkt_bits))
      else $error("Momentary outputs differ from packet.");
   reply_a: assert property (
      (low_power_n && $stable(reply_permit))[*4] ##0 core_in.pkt_valid
      |=> core_out.reply_req == $past(reply_permit))
      else $error("Reply request wrong.");
   ack_rise_a: assert property (
      low_power_n[*4] ##0 core_in.ack_valid |=> ack_out[*2])
      else $error("Acknowledge output did not rise.");
   cmd_pass_a: assert property (
      low_power_n[*5] |-> cmd_out == $past(core_in.cmd_tx))
      else $error("Command output does not follow engine.");
endmodule

// ### verif/rcp_contacts.sv
// Purpose: Contacts and pushbutton on the far side of the pins.
// Assumes: Status lines and button have weak pull-downs.
// Notes: A contact closes only where the line is not driven.
`timescale 1ns/100ps
module rcp_contacts (
   // Pins.
   input wire logic [7:0] line_out,
   input wire logic [7:0] line_oe,
   output logic [7:0] line_in,
   output logic button,
   // Bench commands.
   input wire logic [7:0] close,
   input wire logic press
);
   // Released lines fall to the pull-down, so no stale level remains.
   always_comb begin
      line_in = (line_out & line_oe) | (close & ~line_oe);
      button = press;
   end
endmodule

// ### verif/rcp_pin_logic_test.sv
// Purpose: Self-checking bench for the remote control pin logic.
// Assumes: Millisecond tick shortened to four cycles.
// Notes: The radio engine side is driven straight from the bench.
`timescale 1ns/100ps
module rcp_pin_logic_test;
   localparam int MS = 4;
   logic aclk = 0, aresetn = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] line_in, line_out, line_oe, close = 0, expv, prv;
   logic lo_dir = 0, hi_dir = 0, lp_n = 1, tog = 0, permit = 0;
   logic press = 0, cmd_in = 1, cmd_out, rx_amp, tx_amp, ack, light, btn;
   logic [7:0] tb [5] = '{8'h01, 8'h01, 8'h03, 8'h00, 8'h02};
   int ad [3] = '{20, 5, 20};
   int am [3] = '{0, 0, 3};
   rcp_pkg::rcp_core_in_t core_in = '0;
   rcp_pkg::rcp_core_out_t core_out;
   int n_fail = 0, cmp_count = 0, n_pair = 0, n_fac = 0, n_rep = 0, n, e;

   rcp_pin_logic #(.MS_CYC(MS)) rcp_pin_logic_i (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .status_line_in(line_in),
      .status_line_out(line_out), .status_line_oe(line_oe),
      .low_group_direction(lo_dir), .high_group_direction(hi_dir),
      .low_power_n(lp_n), .toggle_select(tog), .reply_permit(permit),
      .pairing_button(btn), .cmd_in(cmd_in), .cmd_out(cmd_out),
      .rx_amp_enable(rx_amp), .tx_amp_enable(tx_amp), .ack_out(ack),
      .activity_light(light), .core_in(core_in), .core_out(core_out));
   rcp_contacts rcp_contacts_i (.line_out(line_out), .line_oe(line_oe),
      .line_in(line_in), .button(btn), .close(close), .press(press));

   // Clock of 50 ns.
   always #25 aclk = ~aclk;

   // Engine-side pulses are tallied as they stand.
   always @(posedge aclk) begin
      if (core_out.pair_start === 1'b1) n_pair <= n_pair + 1;
      if (core_out.factory_reset === 1'b1) n_fac <= n_fac + 1;
      if (core_out.reply_req === 1'b1) n_rep <= n_rep + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // Address and data go out together; each drops once it is taken.
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (bvalid !== 1'b1) chk(0, 1);
      if (bvalid !== 1'b1) test_done();
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (rvalid !== 1'b1) chk(0, 1);
      if (rvalid !== 1'b1) test_done();
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic pkt(input logic [7:0] b);
      core_in.pkt_valid <= 1'b1;
      core_in.pkt_bits <= b;
      @(posedge aclk);
      core_in.pkt_valid <= 1'b0;
      cyc(2);
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      cyc(8);
      aresetn <= 1'b1;
   endtask

   initial begin
      do_reset();
      cyc(4);
      axi_rd(rcp_pkg::CTRL_OFS);
      chk(rd, 32'h14);
      // Straps are always held at defined levels.
      for (int k = 0; k < 4; k++) begin
         lo_dir <= k[0];
         hi_dir <= k[1];
         cyc(4);
         axi_rd(rcp_pkg::STAT_OFS);
         chk(rd[19:8], {4'h2, {4{!k[1]}}, {4{!k[0]}}});
      end
      close <= 8'h81;
      cyc(12 * MS);
      chk({core_out.send_req, core_out.send_bits}, 9'h181);
      lo_dir <= 1'b0;
      cyc(4 * MS);
      chk(core_out.send_bits, 8'h80);
      close <= 8'h00;
      hi_dir <= 1'b0;
      axi_wr(32'h40, 32'h0);
      chk(resp, rcp_pkg::RESP_SLVERR);
      axi_rd(32'h40);
      chk({rd[1:0], resp}, {2'h0, rcp_pkg::RESP_SLVERR});
      axi_wr(rcp_pkg::STAT_OFS, 32'hffffffff);
      chk(resp, rcp_pkg::RESP_OK);
      // Lit time over one blink period shows the listening state.
      cyc(50 * MS);
      n = 0;
      repeat (1000 * MS) begin
         @(posedge aclk);
         n += int'(light === 1'b1);
      end
      chk(32'(n > 192 && n < 208), 1);
      core_in.rx_busy <= 1'b1;
      cyc(3);
      chk({rx_amp, tx_amp}, 2'b10);
      core_in.rx_busy <= 1'b0;
      core_in.tx_busy <= 1'b1;
      core_in.cmd_tx <= 1'b1;
      cmd_in <= 1'b0;
      cyc(4);
      chk({rx_amp, tx_amp, core_out.cmd_rx, cmd_out}, 4'b0101);
      core_in.tx_busy <= 1'b0;
      core_in.cmd_tx <= 1'b0;
      cmd_in <= 1'b1;
      // Back-to-back packets, then one refused a reply.
      permit <= 1'b1;
      cyc(4);
      e = n_rep;
      core_in.pkt_valid <= 1'b1;
      core_in.pkt_bits <= 8'ha5;
      @(posedge aclk);
      core_in.pkt_bits <= 8'h5a;
      @(posedge aclk);
      core_in.pkt_valid <= 1'b0;
      chk(line_out, 8'ha5);
      @(posedge aclk);
      chk(line_out, 8'h5a);
      permit <= 1'b0;
      cyc(4);
      pkt(8'h0f);
      chk(32'(n_rep - e), 2);
      cyc(700 * MS);
      chk(line_out, 8'h0f);
      cyc(70 * MS);
      chk(line_out, 8'h00);
      lp_n <= 1'b0;
      cyc(4);
      pkt(8'hff);
      chk({line_oe, line_out, core_out.sleep}, 17'h1);
      lp_n <= 1'b1;
      do_reset();
      @(posedge aclk);
      chk({line_oe, line_out, ack}, 17'h0);
      tog <= 1'b1;
      cyc(4);
      expv = 8'h00;
      prv = 8'h00;
      // Outputs flip only where a bit rises against the last packet.
      foreach (tb[i]) begin
         pkt(tb[i]);
         expv = expv ^ (tb[i] & ~prv);
         prv = tb[i];
         chk(line_out, expv);
      end
      // Acknowledge length from the default or from the reply.
      for (int k = 0; k < 3; k++) begin
         axi_wr(rcp_pkg::CTRL_OFS, 32'(ad[k]));
         e = (am[k] != 0) ? am[k] : ad[k];
         core_in.ack_ms <= 8'(am[k]);
         core_in.ack_valid <= 1'b1;
         @(posedge aclk);
         core_in.ack_valid <= 1'b0;
         @(posedge aclk);
         for (n = 0; n < 400 && ack === 1'b1; n++) @(posedge aclk);
         chk(32'(n >= (e - 1) * MS && n <= (e + 1) * MS), 1);
      end
      e = n_pair;
      axi_wr(rcp_pkg::CTRL_OFS, 32'h114);
      axi_wr(rcp_pkg::CTRL_OFS, 32'h05);
      chk(32'(n_pair - e), 1);
      repeat (5) begin
         press <= 1'b1;
         cyc(10 * MS);
         press <= 1'b0;
         cyc(10 * MS);
      end
      cyc(4 * MS);
      chk(32'(n_pair - e), 6);
      chk(32'(n_fac), 1);
      axi_rd(rcp_pkg::CTRL_OFS);
      chk(rd, 32'h14);
      test_done();
   end
endmodule

bind rcp_pin_logic rcp_pin_checker rcp_pin_checker_i (.aclk, .aresetn,
   .low_group_direction, .high_group_direction, .low_power_n,
   .toggle_select, .reply_permit, .status_line_out, .status_line_oe,
   .rx_amp_enable, .tx_amp_enable, .cmd_out, .ack_out, .core_in,
   .core_out);
